// ==== cca_pkg.sv ====
package cca_pkg;

    // array shape
    localparam int CCA_CHANNELS    = 16;
    localparam int CCA_TIMERS      = 2;
    localparam int CCA_WIDTH       = 16;
    localparam int CCA_PAIR_OFFSET = 8;
    localparam int CCA_PRE_BITS    = 7;
    localparam int CCA_PRE_SEL_W   = 3;

    // staggered operation: one timer step every eight system clocks
    localparam int             CCA_STAGGER_DIV  = 8;
    localparam logic [2:0]     CCA_STG_LAST     = 3'h7;

    // counter limits and reset values
    localparam logic [15:0]    CCA_TIMER_MAX    = 16'hFFFF;
    localparam logic [15:0]    CCA_TIMER_RST    = 16'h0000;
    localparam logic [15:0]    CCA_RELOAD_RST   = 16'h0000;
    localparam logic [15:0]    CCA_VALUE_RST    = 16'h0000;
    localparam logic [15:0]    CCA_ONE          = 16'h0001;
    localparam logic [6:0]     CCA_PRE_RST      = 7'h00;
    localparam logic [6:0]     CCA_PRE_ONE      = 7'h01;
    localparam logic [6:0]     CCA_PRE_ALL      = 7'h7F;
    localparam logic [2:0]     CCA_STG_RST      = 3'h0;
    localparam logic [2:0]     CCA_STG_ONE      = 3'h1;
    localparam logic [2:0]     CCA_PRE_SEL_RST  = 3'h0;

    typedef logic [CCA_WIDTH-1:0] cca_word_t;

    // channel operating modes
    typedef enum logic [3:0] {
        cca_mode_off,
        cca_mode_cap_rise,
        cca_mode_cap_fall,
        cca_mode_cap_both,
        cca_mode_cmp0,
        cca_mode_cmp1,
        cca_mode_cmp2,
        cca_mode_cmp3,
        cca_mode_cmp_dbl
    } cca_mode_e;

    // timer count sources
    typedef enum logic [1:0] {
        cca_src_prescaler,
        cca_src_aux_ovf,
        cca_src_ext_count
    } cca_src_e;

endpackage

// ==== cca_sync.sv ====
`timescale 1ns/1ps
module cca_sync (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic pin_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic level_ff;
    logic rise_ff;
    logic fall_ff;
    logic agree;
    logic nxt_level;

    // a change counts only once the second and third stages agree
    assign agree     = (s2_ff == s3_ff);
    assign nxt_level = agree ? s3_ff : level_ff;

    // s1 is read by s2 alone, metastability stays in the first stage
    always_ff @(posedge clk) begin
        if (srst) begin
            s1_ff    <= 1'b0;
            s2_ff    <= 1'b0;
            s3_ff    <= 1'b0;
            level_ff <= 1'b0;
            rise_ff  <= 1'b0;
            fall_ff  <= 1'b0;
        end else begin
            s1_ff    <= pin_in;
            s2_ff    <= s1_ff;
            s3_ff    <= s2_ff;
            level_ff <= nxt_level;
            rise_ff  <= nxt_level & ~level_ff;
            fall_ff  <= ~nxt_level & level_ff;
        end
    end

    assign level = level_ff;
    assign rise  = rise_ff;
    assign fall  = fall_ff;
endmodule

// ==== cca_timer.sv ====
`timescale 1ns/1ps
module cca_timer
    import cca_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               srst,
    input  wire logic               tick,
    input  wire logic               cnt_wr,
    input  wire cca_pkg::cca_word_t cnt_wdata,
    input  wire logic               reload_wr,
    input  wire cca_pkg::cca_word_t reload_wdata,
    output cca_pkg::cca_word_t      cnt,
    output logic                    step,
    output logic                    ovf
);
    cca_word_t cnt_ff;
    cca_word_t reload_ff;
    logic      step_ff;
    logic      ovf_ff;
    logic      at_max;
    cca_word_t nxt_cnt;

    // wrap reloads instead of rolling to zero, the reload sets the period
    assign at_max  = (cnt_ff == CCA_TIMER_MAX);
    assign nxt_cnt = cnt_wr ? cnt_wdata :
                     !tick  ? cnt_ff :
                     at_max ? reload_ff : cnt_ff + CCA_ONE;

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_ff    <= CCA_TIMER_RST;
            reload_ff <= CCA_RELOAD_RST;
            step_ff   <= 1'b0;
            ovf_ff    <= 1'b0;
        end else begin
            cnt_ff    <= nxt_cnt;
            reload_ff <= reload_wr ? reload_wdata : reload_ff;
            step_ff   <= tick & ~cnt_wr;
            ovf_ff    <= tick & ~cnt_wr & at_max;
        end
    end

    assign cnt  = cnt_ff;
    assign step = step_ff;
    assign ovf  = ovf_ff;
endmodule

// ==== cca_array.sv ====
`timescale 1ns/1ps
module cca_array (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               srst,

    // configuration, taken on cfg_load
    input  wire logic               cfg_load,
    input  cca_pkg::cca_mode_e      chan_mode      [cca_pkg::CCA_CHANNELS],
    input  wire logic [15:0]        chan_timer_sel,
    input  wire logic [15:0]        chan_single,
    input  wire logic               stagger_en,
    input  wire logic [1:0]         tmr_run,
    input  cca_pkg::cca_src_e       tmr_src        [cca_pkg::CCA_TIMERS],
    input  wire logic [2:0]         tmr_pre        [cca_pkg::CCA_TIMERS],

    // software writes
    input  wire logic [15:0]        chan_wr,
    input  wire cca_pkg::cca_word_t chan_wdata,
    input  wire logic [1:0]         tmr_wr,
    input  wire cca_pkg::cca_word_t tmr_wdata,
    input  wire logic [1:0]         reload_wr,
    input  wire cca_pkg::cca_word_t reload_wdata,

    // count sources from outside the array
    input  wire logic               aux_ovf,
    input  wire logic [1:0]         ext_count_in,

    // channel pins
    input  wire logic [15:0]        chan_pin_in,
    output logic [15:0]             chan_pin_out,
    output logic [15:0]             chan_pin_oe_n,

    // results
    output cca_pkg::cca_word_t      chan_value     [cca_pkg::CCA_CHANNELS],
    output logic [15:0]             chan_irq,
    output cca_pkg::cca_word_t      timer_value    [cca_pkg::CCA_TIMERS],
    output logic [1:0]              timer_ovf
);
    import cca_pkg::*;

    // stored configuration
    // copied only on cfg_load, so a write never half-applies
    cca_mode_e   mode_ff   [CCA_CHANNELS];
    logic [15:0] tsel_ff;
    logic [15:0] single_ff;
    logic        stagger_ff;
    logic [1:0]  run_ff;
    cca_src_e    src_ff    [CCA_TIMERS];
    logic [2:0]  pre_ff    [CCA_TIMERS];

    // shared dividers
    // one prescaler counter serves both timer taps
    logic [6:0]  pre_cnt_ff;
    logic [2:0]  stg_cnt_ff;
    logic        stg_hit;

    // timer results
    // step and wrap pulses line up with the new count
    cca_word_t   t_cnt     [CCA_TIMERS];
    logic [1:0]  t_step;
    logic [1:0]  t_ovf;
    logic [1:0]  t_tick;
    logic [1:0]  ext_rise;

    // channel state
    // fired is the once-per-period latch, spent the single-event one
    cca_word_t   val_ff    [CCA_CHANNELS];
    logic [15:0] pin_ff;
    logic [15:0] oe_n_ff;
    logic [15:0] irq_ff;
    logic [15:0] fired_ff;
    logic [15:0] spent_ff;
    logic [15:0] pin_rise;
    logic [15:0] pin_fall;

    // prescaler tap: true on the last cycle of a 2^sel period
    // sel low bits all ones mark that cycle; sel of zero ticks every clock
    // free-running, so the first tick after a start may come early
    function automatic logic pre_hit(input logic [6:0] cnt, input logic [2:0] sel);
        logic [6:0] mask;
        mask = CCA_PRE_ALL >> (3'h7 - sel);
        return (cnt & mask) == mask;
    endfunction

    // modes that own the pin as an output
    // the enable is derived, so a capture pin is never driven
    function automatic logic drives_pin(input cca_mode_e m);
        return (m == cca_mode_cmp1) || (m == cca_mode_cmp3) || (m == cca_mode_cmp_dbl);
    endfunction

    // modes that compare rather than capture
    function automatic logic is_compare(input cca_mode_e m);
        return (m == cca_mode_cmp0) || (m == cca_mode_cmp1) || (m == cca_mode_cmp2) ||
               (m == cca_mode_cmp3) || (m == cca_mode_cmp_dbl);
    endfunction

    // timer and global config; reset leaves every channel off
    // timers stay stopped until software runs them
    always_ff @(posedge clk) begin
        if (srst) begin
            tsel_ff    <= 16'h0000;
            single_ff  <= 16'h0000;
            stagger_ff <= 1'b0;
            run_ff     <= 2'h0;
        end else if (cfg_load) begin
            tsel_ff    <= chan_timer_sel;
            single_ff  <= chan_single;
            stagger_ff <= stagger_en;
            run_ff     <= tmr_run;
        end
    end

    // free running dividers; stagger gives one step per eight clocks
    // shared by both timers, so their ticks stay in phase
    // never restarted by cfg_load: a reload keeps the divider phase
    always_ff @(posedge clk) begin
        if (srst) begin
            pre_cnt_ff <= CCA_PRE_RST;
            stg_cnt_ff <= CCA_STG_RST;
        end else begin
            pre_cnt_ff <= pre_cnt_ff + CCA_PRE_ONE;
            stg_cnt_ff <= stg_cnt_ff + CCA_STG_ONE;
        end
    end

    // last stagger count opens the timer gate
    assign stg_hit = (stg_cnt_ff == CCA_STG_LAST);

    // external count inputs come from pins and are synchronised
    // a pin change becomes a tick about four clocks later
    // single-clock pulses are filtered out, the price of the agree test
    genvar e;
    generate
        for (e = 0; e < CCA_TIMERS; e++) begin : g_ext
            cca_sync u_ext_sync (
                .clk    (clk),
                .srst   (srst),
                .pin_in (ext_count_in[e]),
                .level  (),
                .rise   (ext_rise[e]),
                .fall   ()
            );
        end
    endgenerate

    // two time bases, each with its own source and prescaler
    // the source pick is decoded once per timer
    genvar t;
    generate
        for (t = 0; t < CCA_TIMERS; t++) begin : g_tmr
            logic src_tick;
            logic gate;

            // per-timer source and prescaler, taken on cfg_load
            always_ff @(posedge clk) begin
                if (srst) begin
                    src_ff[t] <= cca_src_prescaler;
                    pre_ff[t] <= CCA_PRE_SEL_RST;
                end else if (cfg_load) begin
                    src_ff[t] <= tmr_src[t];
                    pre_ff[t] <= tmr_pre[t];
                end
            end

            // aux overflow is on our clock, so it needs no synchroniser
            // external counts arrive already edge-detected
            assign src_tick = (src_ff[t] == cca_src_aux_ovf)   ? aux_ovf :
                              (src_ff[t] == cca_src_ext_count) ? ext_rise[t] :
                              pre_hit(pre_cnt_ff, pre_ff[t]);
            // stagger coarsens resolution to eight clocks
            // the gate adds no latency to the tick
            assign gate      = run_ff[t] & (~stagger_ff | stg_hit);
            assign t_tick[t] = src_tick & gate;

            // counter and reload register; a software load beats a tick
            cca_timer u_timer (
                .clk          (clk),
                .srst         (srst),
                .tick         (t_tick[t]),
                .cnt_wr       (tmr_wr[t]),
                .cnt_wdata    (tmr_wdata),
                .reload_wr    (reload_wr[t]),
                .reload_wdata (reload_wdata),
                .cnt          (t_cnt[t]),
                .step         (t_step[t]),
                .ovf          (t_ovf[t])
            );

            // results come straight from the timer flip-flops
            assign timer_value[t] = t_cnt[t];
            assign timer_ovf[t]   = t_ovf[t];
        end
    endgenerate

    // sixteen channels, each with its pin, register and event logic
    // each channel reads both timers, the lower eight also their partner's register
    genvar i;
    generate
        for (i = 0; i < CCA_CHANNELS; i++) begin : g_ch
            // partner index only matters in the lower half
            localparam int PARTNER = (i + CCA_PAIR_OFFSET) % CCA_CHANNELS;
            localparam bit HAS_PAIR = (i < CCA_PAIR_OFFSET);

            // selected timer as seen by this channel
            cca_word_t cnt_i;
            logic      step_i;
            logic      ovf_i;

            // gating, match and capture terms
            logic      armed;
            logic      match_own;
            logic      match_par;
            logic      cap_ev;

            // compare events and the pin next state
            logic      ev0;
            logic      ev1;
            logic      ev2;
            logic      ev3;
            logic      evd;
            logic      cmp_ev;
            logic      toggle;
            logic      nxt_pin;

            // pin as capture trigger, filtered like the count inputs
            cca_sync u_pin_sync (
                .clk    (clk),
                .srst   (srst),
                .pin_in (chan_pin_in[i]),
                .level  (),
                .rise   (pin_rise[i]),
                .fall   (pin_fall[i])
            );

            // per-channel timer selection
            // one select bit steers count, step and wrap together
            assign cnt_i  = tsel_ff[i] ? t_cnt[1] : t_cnt[0];
            assign step_i = tsel_ff[i] ? t_step[1] : t_step[0];
            assign ovf_i  = tsel_ff[i] ? t_ovf[1] : t_ovf[0];

            // compared once per timer step, so a paused timer matches once only
            // a software load of the timer never counts as a match
            assign match_own = step_i & (cnt_i == val_ff[i]);
            // pairs are i and i+8; the upper eight see only their own value
            assign match_par = HAS_PAIR & step_i & (cnt_i == val_ff[PARTNER]);

            // single event channels stop after their first event
            // only a cfg_load rearms them, software must reload to repeat
            assign armed = ~(single_ff[i] & spent_ff[i]);

            // capture edge selection
            // edges arrive some four clocks after the pin moves
            assign cap_ev = armed &
                ((mode_ff[i] == cca_mode_cap_rise & pin_rise[i]) |
                 (mode_ff[i] == cca_mode_cap_fall & pin_fall[i]) |
                 (mode_ff[i] == cca_mode_cap_both & (pin_rise[i] | pin_fall[i])));

            // compare actions per mode
            // modes 2 and 3 hold off until their timer wraps
            assign ev0 = armed & (mode_ff[i] == cca_mode_cmp0) & match_own;
            assign ev1 = armed & (mode_ff[i] == cca_mode_cmp1) & match_own;
            assign ev2 = armed & (mode_ff[i] == cca_mode_cmp2) & match_own & ~fired_ff[i];
            assign ev3 = armed & (mode_ff[i] == cca_mode_cmp3) & match_own & ~fired_ff[i];
            assign evd = armed & (mode_ff[i] == cca_mode_cmp_dbl) & (match_own | match_par);
            assign cmp_ev = ev0 | ev1 | ev2 | ev3 | evd;
            assign toggle = ev1 | evd;

            // in mode 3 the match set beats a same-cycle overflow clear
            // toggling modes never meet ev3, so the order matters for mode 3 only
            assign nxt_pin = toggle ? ~pin_ff[i] :
                             ev3    ? 1'b1 :
                             (mode_ff[i] == cca_mode_cmp3 && ovf_i) ? 1'b0 :
                             pin_ff[i];

            // mode is held internally; reset forces it off
            // a new mode acts the cycle after cfg_load
            always_ff @(posedge clk) begin
                if (srst) begin
                    mode_ff[i] <= cca_mode_off;
                end else if (cfg_load) begin
                    mode_ff[i] <= chan_mode[i];
                end
            end

            // capture has priority over a software write in the same cycle
            // so a write in a capture cycle is lost
            always_ff @(posedge clk) begin
                if (srst) begin
                    val_ff[i] <= CCA_VALUE_RST;
                end else if (cap_ev) begin
                    val_ff[i] <= cnt_i;
                end else if (chan_wr[i]) begin
                    val_ff[i] <= chan_wdata;
                end
            end

            // pin, interrupt and one-per-period bookkeeping
            // the output enable follows the mode one clock later
            always_ff @(posedge clk) begin
                if (srst) begin
                    pin_ff[i]   <= 1'b0;
                    oe_n_ff[i]  <= 1'b1;
                    irq_ff[i]   <= 1'b0;
                    fired_ff[i] <= 1'b0;
                    spent_ff[i] <= 1'b0;
                end else begin
                    pin_ff[i]   <= nxt_pin;
                    oe_n_ff[i]  <= ~drives_pin(mode_ff[i]);
                    irq_ff[i]   <= cap_ev | cmp_ev;
                    // set wins over the overflow clear
                    fired_ff[i] <= (ev2 | ev3) | (fired_ff[i] & ~ovf_i);
                    // rearmed by reconfiguring, unless an event lands now
                    spent_ff[i] <= (cap_ev | cmp_ev) | (spent_ff[i] & ~cfg_load);
                end
            end

            // results leave straight from their flip-flops
            assign chan_value[i] = val_ff[i];
            // capture-mode or off channels stay released even if compare bits linger
            assign chan_pin_out[i]  = pin_ff[i];
            assign chan_pin_oe_n[i] = oe_n_ff[i];
            assign chan_irq[i]      = irq_ff[i];
        end
    endgenerate

endmodule

// ==== cca_properties.sv ====
`timescale 1ns/1ps
module cca_props
    import cca_pkg::*;
(
    input wire logic               clk,
    input wire logic               srst,
    input wire logic               cfg_load,
    input wire logic [1:0]         tmr_wr,
    input wire cca_pkg::cca_word_t tmr_wdata,
    input wire logic [15:0]        chan_pin_out,
    input wire logic [15:0]        chan_pin_oe_n,
    input wire logic [15:0]        chan_irq,
    input wire cca_pkg::cca_word_t timer_value [cca_pkg::CCA_TIMERS],
    input wire logic [1:0]         timer_ovf
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    // quiet interrupts, released pins and timer 0 at zero right after release
    chk_reset_quiet: assert property ($fell(srst) |-> chan_irq == 16'h0000
        && chan_pin_oe_n == 16'hFFFF && timer_value[0] == 16'h0000)
        else $error("outputs not idle after reset");
    // a wrap flag always follows the top count
    chk_wrap_top0: assert property (timer_ovf[0] |-> $past(timer_value[0]) == 16'hFFFF)
        else $error("timer 0 flagged a wrap off the top count");
    chk_wrap_top1: assert property (timer_ovf[1] |-> $past(timer_value[1]) == 16'hFFFF)
        else $error("timer 1 flagged a wrap off the top count");
    // leaving the top count without a write must flag the wrap
    chk_wrap_flag: assert property (!$past(srst) && !$past(tmr_wr[0])
        && $past(timer_value[0]) == 16'hFFFF && $changed(timer_value[0]) |-> timer_ovf[0])
        else $error("timer 0 wrapped without its flag");
    // plain counting only ever adds one
    chk_step_one: assert property (!$past(srst) && !$past(tmr_wr[0])
        && !timer_ovf[0] && $changed(timer_value[0])
        |-> timer_value[0] == 16'($past(timer_value[0]) + 16'h0001))
        else $error("timer 0 skipped a count");
    chk_write_load: assert property (tmr_wr[0] |=> timer_value[0] == $past(tmr_wdata))
        else $error("timer 0 missed a software load");
    // driver enables move only after a configuration load
    chk_oe_cfg: assert property (!$past(srst) && $changed(chan_pin_oe_n)
        |-> $past(cfg_load) || $past(cfg_load, 2) || $past(cfg_load, 3))
        else $error("pin enable moved without configuration");
    // an undriven pin never changes its output level
    chk_pin_owned: assert property (!$past(srst) && $changed(chan_pin_out)
        |-> ((chan_pin_out ^ $past(chan_pin_out)) & chan_pin_oe_n
        & $past(chan_pin_oe_n)) == 16'h0000)
        else $error("undriven pin changed level");

    cover property (timer_ovf[0]);
    cover property ($rose(chan_pin_out[3]));
    cover property (chan_irq[10] ##[1:40] chan_irq[10]);
endmodule

bind cca_array cca_props cca_props_i (.clk(clk), .srst(srst), .cfg_load(cfg_load),
    .tmr_wr(tmr_wr), .tmr_wdata(tmr_wdata), .chan_pin_out(chan_pin_out),
    .chan_pin_oe_n(chan_pin_oe_n), .chan_irq(chan_irq), .timer_value(timer_value),
    .timer_ovf(timer_ovf));

// ==== cca_pin_model.sv ====
`timescale 1ns/1ps
module cca_pin_model (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [15:0] flip_req,
    input  wire logic [1:0]  cnt_req,
    input  wire logic [15:0] pin_out,
    input  wire logic [15:0] pin_oe_n,
    output logic [15:0]      pin_level,
    output logic [1:0]       cnt_pin
);
    logic [15:0] ext_ff;
    logic [1:0]  cnt_ff;

    // outside levels move only on request and then hold for the synchroniser
    always_ff @(posedge clk) begin
        if (srst) begin
            ext_ff <= 16'h0000;
            cnt_ff <= 2'h0;
        end else begin
            ext_ff <= ext_ff ^ flip_req;
            cnt_ff <= cnt_ff ^ cnt_req;
        end
    end

    // a driven pin shows the array's level, otherwise the outside one
    assign pin_level = (pin_oe_n & ext_ff) | (~pin_oe_n & pin_out);
    assign cnt_pin   = cnt_ff;
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
    import cca_pkg::*;
    logic        clk, srst, cfg_load, stagger_en, aux_ovf;
    logic [15:0] sel, single, chan_wr, pin_out, oe_n, pin_lvl, irq, flip, pin_prev;
    logic [1:0]  tmr_run, tmr_wr, reload_wr, cnt_req, cnt_pin, t_ovf;
    cca_word_t   chan_wdata, tmr_wdata, reload_wdata;
    cca_mode_e   chan_mode [CCA_CHANNELS];
    cca_src_e    tmr_src [CCA_TIMERS];
    logic [2:0]  tmr_pre [CCA_TIMERS];
    cca_word_t   chan_value [CCA_CHANNELS];
    cca_word_t   timer_value [CCA_TIMERS];
    int          n_errors, checks, cycles, n_ovf;
    int          n_irq [16];
    int          n_tog [16];

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    cca_array cca_array_i (.clk(clk), .srst(srst), .cfg_load(cfg_load),
        .chan_mode(chan_mode), .chan_timer_sel(sel), .chan_single(single),
        .stagger_en(stagger_en), .tmr_run(tmr_run), .tmr_src(tmr_src), .tmr_pre(tmr_pre),
        .chan_wr(chan_wr), .chan_wdata(chan_wdata), .tmr_wr(tmr_wr), .tmr_wdata(tmr_wdata),
        .reload_wr(reload_wr), .reload_wdata(reload_wdata), .aux_ovf(aux_ovf),
        .ext_count_in(cnt_pin), .chan_pin_in(pin_lvl), .chan_pin_out(pin_out),
        .chan_pin_oe_n(oe_n), .chan_value(chan_value), .chan_irq(irq),
        .timer_value(timer_value), .timer_ovf(t_ovf));

    cca_pin_model cca_pin_model_i (.clk(clk), .srst(srst), .flip_req(flip),
        .cnt_req(cnt_req), .pin_out(pin_out), .pin_oe_n(oe_n), .pin_level(pin_lvl),
        .cnt_pin(cnt_pin));

    // event counters; the cycle ceiling cuts a hang short
    always @(posedge clk) begin
        cycles++;
        for (int i = 0; i < 16; i++) begin
            if (irq[i] === 1'b1) n_irq[i]++;
            if (pin_out[i] !== pin_prev[i]) n_tog[i]++;
        end
        if (t_ovf[0] === 1'b1) n_ovf++;
        pin_prev = pin_out;
        if (cycles == 3000) begin
            n_errors++;
            report_and_stop();
        end
    end

    task automatic report_and_stop;
        if (n_errors == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // every task starts and ends just after a falling edge
    task automatic load_cfg;
        cfg_load = 1'b1;
        @(negedge clk);
        cfg_load = 1'b0;
    endtask

    task automatic set_tmr(input int t, input cca_word_t v, input cca_word_t rl);
        tmr_wr[t] = 1'b1;
        reload_wr[t] = 1'b1;
        tmr_wdata = v;
        reload_wdata = rl;
        @(negedge clk);
        tmr_wr = 2'b00;
        reload_wr = 2'b00;
    endtask

    task automatic wr_chan(input int i, input cca_word_t v);
        chan_wr[i] = 1'b1;
        chan_wdata = v;
        @(negedge clk);
        chan_wr = 16'h0000;
    endtask

    task automatic clr_counts;
        for (int i = 0; i < 16; i++) begin
            n_irq[i] = 0;
            n_tog[i] = 0;
        end
        n_ovf = 0;
    endtask

    // timer 1 from source s for n active edges, with source events fed meanwhile
    task automatic run_t1(input cca_src_e s, input logic [2:0] p, input logic g, input int n);
        set_tmr(1, 16'h0000, 16'h0000);
        tmr_src[1] = s;
        tmr_pre[1] = p;
        stagger_en = g;
        tmr_run = 2'b10;
        load_cfg();
        for (int k = 0; k < n - 1; k++) begin
            aux_ovf = (s == cca_src_aux_ovf) && (k % 4 == 1);
            cnt_req[1] = (s == cca_src_ext_count) && (k % 8 == 1);
            @(negedge clk);
        end
        aux_ovf = 1'b0;
        cnt_req = 2'b00;
        tmr_run = 2'b00;
        load_cfg();
        repeat (3) @(negedge clk);
    endtask

    initial begin
        {srst, cfg_load, stagger_en, aux_ovf} = 4'h8;
        {sel, single, chan_wr, flip, pin_prev} = 80'h0;
        {tmr_run, tmr_wr, reload_wr, cnt_req} = 8'h00;
        {chan_wdata, tmr_wdata, reload_wdata} = 48'h0;
        {n_errors, checks, cycles} = 96'h0;
        clr_counts();
        for (int i = 0; i < 16; i++) chan_mode[i] = cca_mode_off;
        tmr_src = '{cca_src_prescaler, cca_src_prescaler};
        tmr_pre = '{3'h0, 3'h0};
        repeat (12) @(negedge clk);
        srst = 1'b0;
        chk(oe_n, 16'hFFFF);
        chk(irq | pin_out, 16'h0000);
        // compare modes on timer 0: period of four counts, match at FFFD
        set_tmr(0, 16'hFFFC, 16'hFFFC);
        set_tmr(1, 16'h1234, 16'h0000);
        for (int i = 0; i < 8; i++) wr_chan(i, 16'hFFFD);
        wr_chan(13, 16'hFFFC);
        chan_mode[0] = cca_mode_cmp0;
        chan_mode[1] = cca_mode_cmp1;
        chan_mode[2] = cca_mode_cmp2;
        chan_mode[3] = cca_mode_cmp3;
        chan_mode[4] = cca_mode_cmp0;
        chan_mode[5] = cca_mode_cmp_dbl;
        chan_mode[6] = cca_mode_cmp0;
        chan_mode[13] = cca_mode_cmp_dbl;
        single = 16'h0010;
        sel = 16'h0040;
        tmr_run = 2'b01;
        clr_counts();
        load_cfg();
        repeat (21) @(negedge clk);
        tmr_run = 2'b00;
        load_cfg();
        repeat (6) @(negedge clk);
        chk(timer_value[0], 16'hFFFE);
        chk(16'(n_ovf), 16'h0005);
        chk(16'(n_irq[0]), 16'h0006);
        chk(16'(n_tog[1]), 16'h0006);
        chk(16'(n_irq[2]), 16'h0006);
        chk(16'(n_tog[3]), 16'h000B);
        chk({15'h0, pin_out[3]}, 16'h0001);
        chk(16'(n_irq[4]), 16'h0001);
        chk(16'(n_tog[5]), 16'h000B);
        chk(16'(n_tog[13]), 16'h0005);
        chk(16'(n_irq[6] + n_irq[7]), 16'h0000);
        chk(oe_n, 16'hDFD5);
        // capture on timer 1 held still: rise, fall and both edges
        for (int i = 0; i < 16; i++) chan_mode[i] = cca_mode_off;
        chan_mode[8] = cca_mode_cap_rise;
        chan_mode[9] = cca_mode_cap_fall;
        chan_mode[10] = cca_mode_cap_both;
        sel = 16'h0700;
        load_cfg();
        clr_counts();
        for (int k = 0; k < 2; k++) begin
            flip = 16'h0700;
            @(negedge clk);
            flip = 16'h0000;
            repeat (10) @(negedge clk);
            set_tmr(1, 16'h5678, 16'h0000);
        end
        chk(chan_value[8], 16'h1234);
        chk(chan_value[9], 16'h5678);
        chk(chan_value[10], 16'h5678);
        chk(16'(n_irq[8] + 2 * n_irq[9] + 4 * n_irq[10]), 16'h000B);
        // count sources of timer 1
        run_t1(cca_src_prescaler, 3'h3, 1'b0, 64);
        chk(timer_value[1], 16'h0008);
        run_t1(cca_src_prescaler, 3'h0, 1'b1, 64);
        chk(timer_value[1], 16'h0008);
        run_t1(cca_src_aux_ovf, 3'h0, 1'b0, 64);
        chk(timer_value[1], 16'h0010);
        run_t1(cca_src_ext_count, 3'h0, 1'b0, 64);
        chk(timer_value[1], 16'h0004);
        report_and_stop();
    end
endmodule
